//--- rtl/tprc_pkg.sv
// Shared constants for the test port and reset control block.
// Assumes a 250 MHz core clock and a separate test clock pin.

package tprc_pkg;

   // -------------------------------------------------------------
   // Register map
   // -------------------------------------------------------------
   localparam logic [7:0]  LCC_OFS     = 8'h83;
   localparam logic [7:0]  STAT_OFS    = 8'h84;
   localparam logic [7:0]  LCNT_OFS    = 8'h85;
   localparam int          LCC_TOG_BIT = 15;
   localparam logic        LCC_RST     = 1'h0;
   localparam int          ST_MODE_BIT = 0;
   localparam int          ST_TAP_BIT  = 1;
   localparam int          ST_SHORT_BIT = 2;
   localparam int          ST_PIN_BIT  = 3;
   localparam logic        SHORT_RST   = 1'h0;

   // -------------------------------------------------------------
   // Timing
   // -------------------------------------------------------------
   localparam int RST_HOLD_US  = 500;
   localparam int CLK_MHZ      = 250;
   localparam int RST_HOLD_CYC = RST_HOLD_US * CLK_MHZ;

   // -------------------------------------------------------------
   // Test access port
   // -------------------------------------------------------------
   localparam int          IR_W       = 2;
   localparam logic [1:0]  IR_IDCODE  = 2'h1;
   localparam logic [1:0]  IR_BYPASS  = 2'h3;
   localparam logic [1:0]  IR_CAPTURE = 2'h1;

   typedef enum logic [3:0] {
      TAP_RESET  = 4'h0,
      TAP_IDLE   = 4'h1,
      TAP_SEL_DR = 4'h2,
      TAP_CAP_DR = 4'h3,
      TAP_SH_DR  = 4'h4,
      TAP_EX1_DR = 4'h5,
      TAP_PA_DR  = 4'h6,
      TAP_EX2_DR = 4'h7,
      TAP_UP_DR  = 4'h8,
      TAP_SEL_IR = 4'h9,
      TAP_CAP_IR = 4'ha,
      TAP_SH_IR  = 4'hb,
      TAP_EX1_IR = 4'hc,
      TAP_PA_IR  = 4'hd,
      TAP_EX2_IR = 4'he,
      TAP_UP_IR  = 4'hf
   } tprc_tap_t;

endpackage

//--- rtl/tprc_tap.sv
// Boundary-scan test access port, clocked by the test clock pin.
// Assumes mode select and reset pins arrive unsynchronised here.

`timescale 1ns/1ps

module tprc_tap #(
   parameter logic [31:0] ID_VALUE = 32'h0000_0001 // Arbitrary value.
) (
   input  wire logic tck_i,
   input  wire logic mode_pin_i,
   input  wire logic trst_pin_n_i,
   input  wire logic tms_i,
   input  wire logic tdi_i,
   output logic      tdo_o,
   output logic      tdo_oe_o,
   output logic      active_o
);

   // -------------------------------------------------------------
   // Pin synchronisers in the test clock domain
   // -------------------------------------------------------------
   logic [1:0] pin_in;
   logic [1:0] filt;
   assign pin_in = {trst_pin_n_i, mode_pin_i};

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_sync
         logic s1_ff, s2_ff, s3_ff, f_ff;
         // A change counts once the last two stages agree.
         always_ff @(posedge tck_i) begin
            s1_ff <= pin_in[g];
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            if (s2_ff == s3_ff) begin
               f_ff <= s3_ff;
            end
         end
         assign filt[g] = f_ff;
      end
   endgenerate

   // Outside test mode, or with the reset pin low, the port is held.
   logic tap_rst;
   assign tap_rst = ~filt[0] | ~filt[1];

   // -------------------------------------------------------------
   // Controller state
   // -------------------------------------------------------------
   tprc_pkg::tprc_tap_t st_ff, nxt_st;

   // Standard sixteen-state walk steered by the mode select pin.
   always_comb begin
      nxt_st = st_ff;
      case (st_ff)
         tprc_pkg::TAP_RESET:  nxt_st = tms_i ? tprc_pkg::TAP_RESET  : tprc_pkg::TAP_IDLE;
         tprc_pkg::TAP_IDLE:   nxt_st = tms_i ? tprc_pkg::TAP_SEL_DR : tprc_pkg::TAP_IDLE;
         tprc_pkg::TAP_SEL_DR: nxt_st = tms_i ? tprc_pkg::TAP_SEL_IR : tprc_pkg::TAP_CAP_DR;
         tprc_pkg::TAP_CAP_DR: nxt_st = tms_i ? tprc_pkg::TAP_EX1_DR : tprc_pkg::TAP_SH_DR;
         tprc_pkg::TAP_SH_DR:  nxt_st = tms_i ? tprc_pkg::TAP_EX1_DR : tprc_pkg::TAP_SH_DR;
         tprc_pkg::TAP_EX1_DR: nxt_st = tms_i ? tprc_pkg::TAP_UP_DR  : tprc_pkg::TAP_PA_DR;
         tprc_pkg::TAP_PA_DR:  nxt_st = tms_i ? tprc_pkg::TAP_EX2_DR : tprc_pkg::TAP_PA_DR;
         tprc_pkg::TAP_EX2_DR: nxt_st = tms_i ? tprc_pkg::TAP_UP_DR  : tprc_pkg::TAP_SH_DR;
         tprc_pkg::TAP_UP_DR:  nxt_st = tms_i ? tprc_pkg::TAP_SEL_DR : tprc_pkg::TAP_IDLE;
         tprc_pkg::TAP_SEL_IR: nxt_st = tms_i ? tprc_pkg::TAP_RESET  : tprc_pkg::TAP_CAP_IR;
         tprc_pkg::TAP_CAP_IR: nxt_st = tms_i ? tprc_pkg::TAP_EX1_IR : tprc_pkg::TAP_SH_IR;
         tprc_pkg::TAP_SH_IR:  nxt_st = tms_i ? tprc_pkg::TAP_EX1_IR : tprc_pkg::TAP_SH_IR;
         tprc_pkg::TAP_EX1_IR: nxt_st = tms_i ? tprc_pkg::TAP_UP_IR  : tprc_pkg::TAP_PA_IR;
         tprc_pkg::TAP_PA_IR:  nxt_st = tms_i ? tprc_pkg::TAP_EX2_IR : tprc_pkg::TAP_PA_IR;
         tprc_pkg::TAP_EX2_IR: nxt_st = tms_i ? tprc_pkg::TAP_UP_IR  : tprc_pkg::TAP_SH_IR;
         tprc_pkg::TAP_UP_IR:  nxt_st = tms_i ? tprc_pkg::TAP_SEL_DR : tprc_pkg::TAP_IDLE;
         default:              nxt_st = tprc_pkg::TAP_RESET;
      endcase
   end

   always_ff @(posedge tck_i) begin
      if (tap_rst) begin
         st_ff <= tprc_pkg::TAP_RESET;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // -------------------------------------------------------------
   // Instruction and data shift paths
   // -------------------------------------------------------------
   logic [1:0]  ir_ff, irsh_ff;
   logic [31:0] idsh_ff;
   logic        byp_ff;

   always_ff @(posedge tck_i) begin
      if (tap_rst || st_ff == tprc_pkg::TAP_RESET) begin
         ir_ff   <= tprc_pkg::IR_IDCODE;
         irsh_ff <= tprc_pkg::IR_CAPTURE;
         idsh_ff <= ID_VALUE;
         byp_ff  <= 1'b0;
      end else begin
         case (st_ff)
            tprc_pkg::TAP_CAP_IR: irsh_ff <= tprc_pkg::IR_CAPTURE;
            tprc_pkg::TAP_SH_IR:  irsh_ff <= {tdi_i, irsh_ff[1]};
            tprc_pkg::TAP_UP_IR:  ir_ff   <= irsh_ff;
            tprc_pkg::TAP_CAP_DR: begin
               idsh_ff <= ID_VALUE;
               byp_ff  <= 1'b0;
            end
            tprc_pkg::TAP_SH_DR: begin
               idsh_ff <= {tdi_i, idsh_ff[31:1]};
               byp_ff  <= tdi_i;
            end
            default: ;
         endcase
      end
   end

   // Output changes on the falling edge so the tester samples mid-bit.
   always_ff @(negedge tck_i) begin
      if (tap_rst) begin
         tdo_o    <= 1'b0;
         tdo_oe_o <= 1'b0;
      end else begin
         tdo_oe_o <= (st_ff == tprc_pkg::TAP_SH_IR) || (st_ff == tprc_pkg::TAP_SH_DR);
         if (st_ff == tprc_pkg::TAP_SH_IR) begin
            tdo_o <= irsh_ff[0];
         end else if (ir_ff == tprc_pkg::IR_IDCODE) begin
            tdo_o <= idsh_ff[0];
         end else begin
            tdo_o <= byp_ff;
         end
      end
   end

   // Level that tells the core a scan session is in progress.
   always_ff @(posedge tck_i) begin
      active_o <= ~tap_rst && (st_ff != tprc_pkg::TAP_RESET);
   end

endmodule

//--- rtl/tprc_top.sv
// Test port select, device reset and line counter clear control.
// Operation
// - A toggle of the clear bit resets every line-based counter.
// - Test-port select high turns host port pins into scan pins.
// - Test-port select high makes the reset pin the test reset.
// - Boundary scan works only while in test-port mode.
// - Reset pin low outside test-port mode returns all configuration to defaults.
// Assumes a plain one-cycle register port and a free test clock pin.

`timescale 1ns/1ps

module tprc_top #(
   parameter int RST_HOLD_CYCLES = tprc_pkg::RST_HOLD_CYC,
   parameter int LINE_CNT_W      = 16
) (
   input  wire logic                  clock_i,
   input  wire logic                  reset_i,
   input  wire logic [7:0]            addr_i,
   input  wire logic [15:0]           wdata_i,
   input  wire logic                  wr_i,
   input  wire logic                  rd_i,
   output logic      [15:0]           rdata_o,
   input  wire logic                  test_port_sel_i,
   input  wire logic                  reset_pin_n_i,
   input  wire logic                  line_strobe_i,
   input  wire logic                  test_clock_pin_i,
   input  wire logic                  tdi_pin_i,
   input  wire logic                  tms_pin_i,
   output logic                       tdo_pin_o,
   output logic                       tdo_pin_oe_o,
   output logic                       host_port_en_o,
   output logic                       test_mode_o,
   output logic                       dev_reset_o,
   output logic                       line_counter_clear_o,
   output logic      [LINE_CNT_W-1:0] line_count_o
);

   // -------------------------------------------------------------
   // Elaboration checks
   // -------------------------------------------------------------
   // The read port is sixteen bits wide, so the counter must fit.
   generate
      if (LINE_CNT_W < 1 || LINE_CNT_W > 16) begin : g_bad_w
         $error("LINE_CNT_W must lie between 1 and 16");
      end
      if (RST_HOLD_CYCLES < 1) begin : g_bad_hold
         $error("RST_HOLD_CYCLES must be at least 1");
      end
   endgenerate

   localparam int HOLD_W = $clog2(RST_HOLD_CYCLES + 1);
   localparam logic [HOLD_W-1:0] HOLD_MAX = HOLD_W'(RST_HOLD_CYCLES);

   // -------------------------------------------------------------
   // Test access port on the test clock
   // -------------------------------------------------------------
   logic tap_active;

   // The port keeps its own copy of the select and reset pins,
   // since its clock may stand still whenever no tester is fitted.
   tprc_tap u_tap (
      .tck_i        (test_clock_pin_i),
      .mode_pin_i   (test_port_sel_i),
      .trst_pin_n_i (reset_pin_n_i),
      .tms_i        (tms_pin_i),
      .tdi_i        (tdi_pin_i),
      .tdo_o        (tdo_pin_o),
      .tdo_oe_o     (tdo_pin_oe_o),
      .active_o     (tap_active)
   );

   // -------------------------------------------------------------
   // Pin and crossing synchronisers
   // -------------------------------------------------------------
   // Bit 0 is the select pin, bit 1 the reset pin, bit 2 the
   // scan-activity level from the test clock domain.
   logic [2:0] async_in;
   logic [2:0] filt;

   assign async_in = {tap_active, reset_pin_n_i, test_port_sel_i};

   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_sync
         logic s1_ff;
         logic s2_ff;
         logic s3_ff;
         logic f_ff;

         // Three stages; the filtered copy moves only once the last
         // two agree, so a single late sample cannot cause a glitch.
         always_ff @(posedge clock_i) begin
            if (reset_i) begin
               s1_ff <= 1'b0;
               s2_ff <= 1'b0;
               s3_ff <= 1'b0;
               f_ff  <= 1'b0;
            end else begin
               s1_ff <= async_in[g];
               s2_ff <= s1_ff;
               s3_ff <= s2_ff;
               if (s2_ff == s3_ff) begin
                  f_ff <= s3_ff;
               end
            end
         end

         assign filt[g] = f_ff;
      end
   endgenerate

   logic mode;
   logic pin_rst_n;
   logic scan_busy;

   assign mode      = filt[0];
   assign pin_rst_n = filt[1];
   assign scan_busy = filt[2];

   // -------------------------------------------------------------
   // Device reset
   // -------------------------------------------------------------
   // In test mode the pin belongs to the scan logic and leaves the
   // core alone.
   logic soft_rst;

   assign soft_rst = reset_i | (~pin_rst_n & ~mode);

   // The reset level is registered before it leaves the block.
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         dev_reset_o <= 1'b1;
      end else begin
         dev_reset_o <= soft_rst;
      end
   end

   // -------------------------------------------------------------
   // Port mode outputs
   // -------------------------------------------------------------
   // The host port pins serve the host unless test mode is chosen.
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         host_port_en_o <= 1'b1;
         test_mode_o    <= 1'b0;
      end else begin
         host_port_en_o <= ~mode;
         test_mode_o    <= mode;
      end
   end

   // -------------------------------------------------------------
   // Reset hold monitor
   // -------------------------------------------------------------
   // Counts how long the pin stayed low; a release before the hold
   // time has passed is recorded, since the defaults may then be
   // unreliable on the real part.
   logic [HOLD_W-1:0] hold_cnt_ff;
   logic              pin_prev_ff;
   logic              short_ff;
   logic              short_set;
   logic              short_clr;

   always_ff @(posedge clock_i) begin
      if (reset_i || pin_rst_n || mode) begin
         hold_cnt_ff <= '0;
      end else if (hold_cnt_ff != HOLD_MAX) begin
         hold_cnt_ff <= hold_cnt_ff + 1'b1;
      end
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         pin_prev_ff <= 1'b0;
      end else begin
         pin_prev_ff <= pin_rst_n;
      end
   end

   // A rising pin outside test mode with too short a count.
   assign short_set = pin_rst_n & ~pin_prev_ff & ~mode
                    & (hold_cnt_ff != HOLD_MAX);

   assign short_clr = wr_i && ~mode && (addr_i == tprc_pkg::STAT_OFS)
                    && wdata_i[tprc_pkg::ST_SHORT_BIT];

   // The set wins over a clear in the same cycle.
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         short_ff <= tprc_pkg::SHORT_RST;
      end else if (short_set) begin
         short_ff <= 1'b1;
      end else if (short_clr) begin
         short_ff <= 1'b0;
      end
   end

   // -------------------------------------------------------------
   // Counter clear control register
   // -------------------------------------------------------------
   // Writes are refused in test mode, because the host port pins
   // then carry scan traffic and cannot carry host cycles.
   logic lcc_wr;
   logic lcc_tog_ff;
   logic lcc_prev_ff;

   assign lcc_wr = wr_i && ~mode && (addr_i == tprc_pkg::LCC_OFS);

   // Only the toggle bit is stored; the low bits are discarded.
   always_ff @(posedge clock_i) begin
      if (soft_rst) begin
         lcc_tog_ff <= tprc_pkg::LCC_RST;
      end else if (lcc_wr) begin
         lcc_tog_ff <= wdata_i[tprc_pkg::LCC_TOG_BIT];
      end
   end

   // Both copies reset together, so reset itself gives no pulse.
   always_ff @(posedge clock_i) begin
      if (soft_rst) begin
         lcc_prev_ff <= tprc_pkg::LCC_RST;
      end else begin
         lcc_prev_ff <= lcc_tog_ff;
      end
   end

   // A change in either direction gives one pulse per change.
   always_ff @(posedge clock_i) begin
      if (soft_rst) begin
         line_counter_clear_o <= 1'b0;
      end else begin
         line_counter_clear_o <= lcc_tog_ff ^ lcc_prev_ff;
      end
   end

   // -------------------------------------------------------------
   // Line counter
   // -------------------------------------------------------------
   // The clear pulse takes priority over a line strobe in the
   // same cycle; that line is lost rather than half counted.
   always_ff @(posedge clock_i) begin
      if (soft_rst) begin
         line_count_o <= '0;
      end else if (line_counter_clear_o) begin
         line_count_o <= '0;
      end else if (line_strobe_i) begin
         line_count_o <= line_count_o + 1'b1;
      end
   end

   // -------------------------------------------------------------
   // Read port
   // -------------------------------------------------------------
   logic [15:0] lcnt16;
   logic [15:0] stat16;
   logic [15:0] lcc16;
   logic [15:0] nxt_rdata;

   always_comb begin
      lcnt16 = 16'h0000;
      lcnt16[LINE_CNT_W-1:0] = line_count_o;
   end

   // Status shows the block's own state; unused bits read zero.
   always_comb begin
      stat16 = 16'h0000;
      stat16[tprc_pkg::ST_MODE_BIT]  = mode;
      stat16[tprc_pkg::ST_TAP_BIT]   = scan_busy;
      stat16[tprc_pkg::ST_SHORT_BIT] = short_ff;
      stat16[tprc_pkg::ST_PIN_BIT]   = ~pin_rst_n;
   end

   // Reserved low bits of the clear register read as zero.
   always_comb begin
      lcc16 = 16'h0000;
      lcc16[tprc_pkg::LCC_TOG_BIT] = lcc_tog_ff;
   end

   // Decode; an unmapped address answers zero.
   always_comb begin
      nxt_rdata = 16'h0000;
      if (!rd_i) begin
         nxt_rdata = 16'h0000;
      end else if (addr_i == tprc_pkg::LCC_OFS) begin
         nxt_rdata = lcc16;
      end else if (addr_i == tprc_pkg::STAT_OFS) begin
         nxt_rdata = stat16;
      end else if (addr_i == tprc_pkg::LCNT_OFS) begin
         nxt_rdata = lcnt16;
      end
   end

   // Read data stand for exactly the cycle after the strobe.
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         rdata_o <= 16'h0000;
      end else begin
         rdata_o <= nxt_rdata;
      end
   end

endmodule

//--- bench/tprc_top_properties.sv
// Concurrent checks on the ports of the test port and reset control top.
// Assumes one core clock domain and the one-cycle register port.
`timescale 1ns/1ps
module tprc_top_properties #(
   parameter int LINE_CNT_W = 16
) (
   input wire logic                  clock_i,
   input wire logic                  reset_i,
   input wire logic [7:0]            addr_i,
   input wire logic [15:0]           wdata_i,
   input wire logic                  wr_i,
   input wire logic                  rd_i,
   input wire logic [15:0]           rdata_o,
   input wire logic                  test_port_sel_i,
   input wire logic                  reset_pin_n_i,
   input wire logic                  tdo_pin_oe_o,
   input wire logic                  host_port_en_o,
   input wire logic                  test_mode_o,
   input wire logic                  dev_reset_o,
   input wire logic                  line_counter_clear_o,
   input wire logic [LINE_CNT_W-1:0] line_count_o
);
   // -----------------------------------------------------------
   // Helper logic
   // -----------------------------------------------------------
   logic       take;
   logic       shadow_ff;
   logic       exp1_ff;
   logic       exp2_ff;
   logic [7:0] sel_low_ff;
   // Only writes the core accepts move the expected toggle bit.
   assign take = wr_i && (addr_i == tprc_pkg::LCC_OFS) && !test_mode_o && !dev_reset_o;
   // Expected clear pulse, two cycles behind the accepted write.
   always_ff @(posedge clock_i) begin
      if (reset_i || dev_reset_o) begin
         shadow_ff <= 1'h0;
         exp1_ff   <= 1'h0;
         exp2_ff   <= 1'h0;
      end else begin
         exp1_ff <= take && (wdata_i[15] != shadow_ff);
         exp2_ff <= exp1_ff;
         if (take) begin
            shadow_ff <= wdata_i[15];
         end
      end
   end
   // Cycles with select low; saturates so it never wraps back.
   always_ff @(posedge clock_i) begin
      if (reset_i || test_port_sel_i) begin
         sel_low_ff <= 8'h00;
      end else if (sel_low_ff != 8'h40) begin
         sel_low_ff <= sel_low_ff + 8'h01;
      end
   end
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (reset_i);
   // -----------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------
   clear_pulse_a: assert property (line_counter_clear_o == exp2_ff)
      else $error("Clear pulse does not follow the toggle bit.");
   count_clear_a: assert property (line_counter_clear_o |=> line_count_o == '0)
      else $error("Line count survived a clear pulse.");
   toggle_read_a: assert property (rd_i && addr_i == tprc_pkg::LCC_OFS |=>
      rdata_o == {shadow_ff, 15'h0000}) else $error("Clear register read is wrong.");
   host_off_a: assert property (test_mode_o |-> !host_port_en_o)
      else $error("Host port still enabled in test mode.");
   mode_enter_a: assert property ($rose(test_port_sel_i) |-> ##[1:8] test_mode_o)
      else $error("Test mode not entered after select.");
   scan_off_a: assert property (sel_low_ff == 8'h40 |-> !tdo_pin_oe_o)
      else $error("Scan output driven outside test mode.");
   pin_reset_a: assert property ($fell(reset_pin_n_i) && !test_port_sel_i &&
      !test_mode_o |-> ##[1:8] dev_reset_o) else $error("Reset pin did not reset core.");
   test_reset_a: assert property (test_mode_o && $fell(reset_pin_n_i) |->
      (!dev_reset_o) [*8]) else $error("Reset pin reset the core in test mode.");
   count_reset_a: assert property (dev_reset_o |=> line_count_o == '0)
      else $error("Line count not held at zero in reset.");
endmodule

bind tprc_top tprc_top_properties #(.LINE_CNT_W(LINE_CNT_W)) u_props (
   .clock_i(clock_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
   .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .test_port_sel_i(test_port_sel_i),
   .reset_pin_n_i(reset_pin_n_i), .tdo_pin_oe_o(tdo_pin_oe_o),
   .host_port_en_o(host_port_en_o), .test_mode_o(test_mode_o),
   .dev_reset_o(dev_reset_o), .line_counter_clear_o(line_counter_clear_o),
   .line_count_o(line_count_o));

//--- bench/tprc_scan_model.sv
// Scan test equipment: drives test clock, mode select and data in.
// Assumes the host has let go of the shared pins while it runs.
`timescale 1ns/1ps
module tprc_scan_model (
   output logic      tck_o,
   output logic      tms_o,
   output logic      tdi_o,
   input  wire logic tdo_i,
   input  wire logic tdo_oe_i
);
   int   oe_hits;
   logic line_last;
   // The clock stands still between frames, as real equipment may.
   initial begin
      tck_o     = 1'h0;
      tms_o     = 1'h1;
      tdi_o     = 1'h0;
      line_last = 1'h0;
      oe_hits   = 0;
      repeat (6) step(1'h1, line_last); // Brings the port to its held state.
   end
   // One 15 ns test clock period; a released line shows its inverse.
   task automatic step(input logic m, output logic seen);
      tms_o = m;
      tdi_o = ~tdi_o;
      #7.5;
      seen      = tdo_oe_i ? tdo_i : ~line_last;
      line_last = seen;
      if (tdo_oe_i) begin
         oe_hits++;
      end
      tck_o = 1'h1;
      #7.5;
      tck_o = 1'h0;
   endtask
   // Reset the port, walk to the data shift state, shift 32 bits out.
   task automatic read_id(output logic [31:0] id);
      logic s;
      oe_hits = 0;
      repeat (8) step(1'h1, s);
      step(1'h0, s);
      step(1'h1, s);
      step(1'h0, s);
      step(1'h0, s);
      for (int i = 0; i < 32; i++) begin
         step(i == 31, s);
         id[i] = s;
      end
      step(1'h1, s);
      step(1'h0, s);
   endtask
endmodule

//--- bench/tb.sv
// Self-checking bench for the test port and reset control block.
// Assumes the scan model and the checker are compiled before it.
`timescale 1ns/1ps
module tb;
   localparam int          HOLD   = 20;
   localparam logic [31:0] ID_EXP = 32'h0000_0001; // Arbitrary value.
   logic        clock_i = 1'h0;
   logic        reset_i, wr_i, rd_i, sel, pin_n, strobe;
   logic        tck, tms, tdi, tdo, tdo_oe, host_en, test_mode_o, dev_reset_o, clr;
   logic [7:0]  addr_i;
   logic [15:0] wdata_i, rdata_o, cnt;
   int          bad_count = 0;
   int          total_checks = 0;
   int          cycles = 0;
   // -----------------------------------------------------------
   // Design and partner
   // -----------------------------------------------------------
   tprc_top #(.RST_HOLD_CYCLES(HOLD), .LINE_CNT_W(16)) u_dut (
      .clock_i(clock_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .test_port_sel_i(sel),
      .reset_pin_n_i(pin_n), .line_strobe_i(strobe), .test_clock_pin_i(tck),
      .tdi_pin_i(tdi), .tms_pin_i(tms), .tdo_pin_o(tdo), .tdo_pin_oe_o(tdo_oe),
      .host_port_en_o(host_en), .test_mode_o(test_mode_o), .dev_reset_o(dev_reset_o),
      .line_counter_clear_o(clr), .line_count_o(cnt));
   tprc_scan_model scan (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo),
      .tdo_oe_i(tdo_oe));
   // Core clock at 250 MHz.
   always #2 clock_i = ~clock_i;
   // -----------------------------------------------------------
   // Tasks
   // -----------------------------------------------------------
   task automatic conclude();
      $display("checks %0d, mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clock_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'h1;
      @(posedge clock_i);
      wr_i <= 1'h0;
   endtask
   // Read data stand only in the cycle after the taking edge.
   task automatic rc(input logic [7:0] a, input logic [15:0] exp);
      @(posedge clock_i);
      addr_i <= a;
      rd_i   <= 1'h1;
      @(posedge clock_i);
      rd_i <= 1'h0;
      #1;
      check(32'(rdata_o), 32'(exp));
   endtask
   task automatic pulses(input int n, input int exp);
      int k;
      k = 0;
      repeat (n) begin
         @(posedge clock_i);
         #1;
         if (clr === 1'h1) begin
            k++;
         end
      end
      check(32'(k), 32'(exp));
   endtask
   task automatic strobes(input int n);
      repeat (n) begin
         @(posedge clock_i);
         strobe <= 1'h1;
         @(posedge clock_i);
         strobe <= 1'h0;
      end
   endtask
   // Bounded wait for a level; the filters take a few cycles.
   task automatic wait_lvl(ref logic s, input logic v);
      int k;
      k = 0;
      while (s !== v && k < 60) begin
         @(posedge clock_i);
         k++;
      end
      #1;
      check(32'(s), 32'(v));
   endtask
   // -----------------------------------------------------------
   // Sequence
   // -----------------------------------------------------------
   always @(posedge clock_i) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         conclude();
      end
   end
   initial begin
      logic [31:0] id;
      reset_i = 1'h1;
      {wr_i, rd_i, sel, pin_n, strobe} = 5'h00;
      addr_i  = 8'h00;
      wdata_i = 16'h0000;
      repeat (4) @(posedge clock_i);
      reset_i <= 1'h0;
      repeat (HOLD + 10) @(posedge clock_i);
      pin_n <= 1'h1;
      wait_lvl(dev_reset_o, 1'h0);
      rc(tprc_pkg::LCC_OFS, 16'h0000);
      rc(tprc_pkg::STAT_OFS, 16'h0000);
      rc(8'h90, 16'h0000);
      strobes(3);
      rc(tprc_pkg::LCNT_OFS, 16'h0003);
      wr(tprc_pkg::LCC_OFS, 16'h8000);
      pulses(4, 1);
      rc(tprc_pkg::LCNT_OFS, 16'h0000);
      wr(tprc_pkg::LCC_OFS, 16'h8000);
      pulses(4, 0);
      rc(tprc_pkg::LCC_OFS, 16'h8000);
      // Two toggles back to back give two pulses.
      @(posedge clock_i);
      addr_i  <= tprc_pkg::LCC_OFS;
      wdata_i <= 16'h0000;
      wr_i    <= 1'h1;
      @(posedge clock_i);
      wdata_i <= 16'h8000;
      @(posedge clock_i);
      wr_i <= 1'h0;
      #1;
      check(32'(clr), 32'h1);
      pulses(5, 1);
      wr(tprc_pkg::LCNT_OFS, 16'h1234);
      rc(tprc_pkg::LCNT_OFS, 16'h0000);
      // A short pin reset clears state and raises the short flag.
      strobes(2);
      pin_n <= 1'h0;
      repeat (8) @(posedge clock_i);
      check(32'(dev_reset_o), 32'h1);
      pin_n <= 1'h1;
      wait_lvl(dev_reset_o, 1'h0);
      rc(tprc_pkg::LCC_OFS, 16'h0000);
      rc(tprc_pkg::LCNT_OFS, 16'h0000);
      rc(tprc_pkg::STAT_OFS, 16'h0004);
      wr(tprc_pkg::STAT_OFS, 16'h0004);
      rc(tprc_pkg::STAT_OFS, 16'h0000);
      // Test-port mode: host writes refused, scan port answers.
      sel <= 1'h1;
      wait_lvl(test_mode_o, 1'h1);
      check(32'(host_en), 32'h0);
      wr(tprc_pkg::LCC_OFS, 16'h8000);
      pulses(4, 0);
      scan.read_id(id);
      check(id, ID_EXP);
      @(posedge clock_i);
      pin_n <= 1'h0;
      scan.read_id(id);
      check(32'(scan.oe_hits), 32'h0);
      check(32'(dev_reset_o), 32'h0);
      @(posedge clock_i);
      pin_n <= 1'h1;
      sel   <= 1'h0;
      wait_lvl(test_mode_o, 1'h0);
      rc(tprc_pkg::LCC_OFS, 16'h0000);
      scan.read_id(id);
      check(32'(scan.oe_hits), 32'h0);
      conclude();
   end
endmodule
